// file: verilog/lges_pkg.sv
package lges_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_ENABLE = 8'h14;
  localparam logic [7:0] ADDR_EXT_STATUS = 8'h18;
  localparam logic [7:0] ADDR_TEST_CTRL = 8'h30;
  // ==========================================================
  // field positions
  localparam int BIT_EXT_PENDING = 1;
  localparam int BIT_LOCAL_PENDING = 2;
  localparam int BIT_FIRST_EVENT = 3;
  localparam int BIT_LAST_EVENT = 17;
  localparam int NUM_EVENTS = 15;
  localparam int BIT_DIRECT_ACCESS = 0;
  // ==========================================================
  // reset values and masks
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
  localparam logic [31:0] EVENT_MASK = 32'h0003_fff8;
  localparam logic [31:0] EXT_MASK = 32'hffff_ffff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : lges_pkg

// file: verilog/lges_top.sv
// Summary of operation
// - write one clears status flag, zero keeps
// - flags reset to zero on reset
// - test mode allows direct flag write except bit1 and bit2
// - bit1 reads OR of extended status
// - bit2 reads OR of group-zero flags
// - bit3 set on phy timeout or power drop
// - bit4 set on phy register value arrival
// - bit5 set on serial bus reset entry
// - bit6 set on self-id error
// - bit7 set when transmitter idle
// - bit8 set on async packet confirmed
// - bit9 set on reset-start quadlet write
// - bit10 set on control fifo ack
// - bit11 set on iso last quadlet stored
// - bit12 set on bulky async ack
// - bit13 set on iso tx stall; host flushes
// - bit14 set on async tx stall; host flushes
// - bit15 set on payload crc error
// - bit16 set on busy ack issued
// - bit17 set on header crc error
// - enable register gates flags onto interrupt
//
// Our own choice: the AXI4-Lite register port.
module lges_top
  import lges_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // software reset from the wider controller
  input wire logic soft_reset,
  // event strobes, one-cycle pulses on mclk
  input wire logic phys_layer_alert,
  input wire logic phys_reg_value_arrived,
  input wire logic serial_bus_reset_entered,
  input wire logic self_ident_fault,
  input wire logic transmitter_idle_flag,
  input wire logic async_packet_arrived,
  input wire logic reset_start_write_seen,
  input wire logic ctrl_fifo_ack_seen,
  input wire logic iso_packet_arrived,
  input wire logic bulk_async_ack_seen,
  input wire logic iso_tx_fifo_stalled,
  input wire logic async_tx_fifo_stalled,
  input wire logic payload_check_error,
  input wire logic busy_ack_issued,
  input wire logic header_check_error,
  // extended group status from the group-one register
  input wire logic [31:0] ext_event_status,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // host interrupt
  output logic host_irq
);
  import lges_pkg::*;

  // ==========================================================
  // registers
  logic [31:0] group0_event_status;
  logic [31:0] interrupt_enable_mask;
  logic [31:0] link_test_control_register;
  logic [NUM_EVENTS-1:0] event_in;
  logic [31:0] event_vec;
  logic [31:0] status_view;
  logic local_group_pending;
  logic extended_group_pending;
  logic direct_access_test_bit;

  // ==========================================================
  // write channel capture
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic wr_fire;
  logic [31:0] byte_mask;

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  // address and data taken in either order
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_held <= 1'b0;
    end
  end

  // ready while the slot is empty and no response is pending
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready)
        && !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready)
        && !s_axi_bvalid;
    end
  end

  // write response, slverr on unmapped address
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      case (aw_addr)
        ADDR_STATUS, ADDR_ENABLE, ADDR_TEST_CTRL, ADDR_EXT_STATUS:
          s_axi_bresp <= RESP_OKAY;
        default:
          s_axi_bresp <= RESP_SLVERR;
      endcase
    end
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // byte lanes expanded to bit mask
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++)
    begin : g_lane
      assign byte_mask[gb*8 +: 8] = {8{w_strb[gb]}};
    end
  endgenerate

  // ==========================================================
  // event collection
  assign event_in = {header_check_error, busy_ack_issued,
    payload_check_error, async_tx_fifo_stalled, iso_tx_fifo_stalled,
    bulk_async_ack_seen, iso_packet_arrived, ctrl_fifo_ack_seen,
    reset_start_write_seen, async_packet_arrived, transmitter_idle_flag,
    self_ident_fault, serial_bus_reset_entered, phys_reg_value_arrived,
    phys_layer_alert};
  // bit3..bit17 in order
  assign event_vec = {14'h0000, event_in, 3'h0};

  assign direct_access_test_bit =
    link_test_control_register[BIT_DIRECT_ACCESS];

  // status flags: set, write-one clear or test write
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      group0_event_status <= STATUS_RESET;
    else if (soft_reset)
      group0_event_status <= STATUS_RESET;
    else
    begin
      if (wr_fire && aw_addr == ADDR_STATUS)
      begin
        if (direct_access_test_bit)
          group0_event_status <= ((group0_event_status & ~byte_mask)
            | (w_data & byte_mask) | event_vec) & EVENT_MASK;
        else
          group0_event_status <= ((group0_event_status
            & ~(w_data & byte_mask)) | event_vec)
            & EVENT_MASK;
      end
      else
        group0_event_status <= (group0_event_status | event_vec)
          & EVENT_MASK;
    end
  end

  // enable and test control registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      interrupt_enable_mask <= ENABLE_RESET;
      link_test_control_register <= 32'h0000_0000;
    end
    else if (soft_reset)
    begin
      interrupt_enable_mask <= ENABLE_RESET;
      link_test_control_register <= 32'h0000_0000;
    end
    else if (wr_fire && aw_addr == ADDR_ENABLE)
      interrupt_enable_mask <= (interrupt_enable_mask & ~byte_mask)
        | (w_data & byte_mask);
    else if (wr_fire && aw_addr == ADDR_TEST_CTRL)
      link_test_control_register <= {31'h0000_0000,
        (w_strb[0] ? w_data[BIT_DIRECT_ACCESS]
        : direct_access_test_bit)};
  end

  // ==========================================================
  // summary bits
  assign local_group_pending = |(group0_event_status & EVENT_MASK);
  assign extended_group_pending = |(ext_event_status & EXT_MASK);

  // read view of status register
  always_comb
  begin
    status_view = group0_event_status;
    status_view[BIT_EXT_PENDING] = extended_group_pending;
    status_view[BIT_LOCAL_PENDING] = local_group_pending;
  end

  // ==========================================================
  // read channel
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        ADDR_STATUS: s_axi_rdata <= status_view;
        ADDR_ENABLE: s_axi_rdata <= interrupt_enable_mask;
        ADDR_EXT_STATUS: s_axi_rdata <= ext_event_status;
        ADDR_TEST_CTRL: s_axi_rdata <= link_test_control_register;
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else
      s_axi_arready <= 1'b1;
  end

  // ==========================================================
  // host interrupt from enabled flags
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      host_irq <= 1'b0;
    else
      host_irq <= |(status_view & interrupt_enable_mask
        & (EVENT_MASK | 32'h0000_0002));
  end
endmodule : lges_top

// file: testbench/lges_checker.sv
// ====
// bus and interrupt checker
module lges_chk
  import lges_pkg::*;
(
  // clock and resets
  input wire logic mclk,
  input wire logic rst,
  input wire logic soft_reset,
  // write side
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read side
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  input wire logic host_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // read address taken
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stayed after handshake");
  w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data unstable");
  r_answer_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  bad_read_a: assert property (rd_take ##0 s_axi_araddr == 8'h20 |=>
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read answered wrongly");
  irq_reset_a: assert property (soft_reset |-> ##2 !host_irq)
    else $error("interrupt after soft reset");
endmodule : lges_chk

bind lges_top lges_chk chk (.*);

// file: testbench/test_link_group0_event_status.sv
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch %0t %h %h", $time, a, b); end end
// ====
// bench top
module test_link_group0_event_status
  import lges_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, soft_reset = 0;
  logic [14:0] ev = '0;
  logic [31:0] ext = '0, wd = '0, st, v;
  logic [7:0] aa = '0, ra = '0;
  logic av = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic awr, wrd, bv, arr, rv, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int err_count = 0, cmp_count = 0;
  logic [33:0] rq[$];
  logic [1:0] wq[$];
  logic [33:0] re;
  logic [1:0] we;
  lges_top dut (
    .mclk(mclk), .rst(rst), .soft_reset(soft_reset),
    .phys_layer_alert(ev[0]), .phys_reg_value_arrived(ev[1]),
    .serial_bus_reset_entered(ev[2]), .self_ident_fault(ev[3]),
    .transmitter_idle_flag(ev[4]), .async_packet_arrived(ev[5]),
    .reset_start_write_seen(ev[6]), .ctrl_fifo_ack_seen(ev[7]),
    .iso_packet_arrived(ev[8]), .bulk_async_ack_seen(ev[9]),
    .iso_tx_fifo_stalled(ev[10]), .async_tx_fifo_stalled(ev[11]),
    .payload_check_error(ev[12]), .busy_ack_issued(ev[13]),
    .header_check_error(ev[14]), .ext_event_status(ext),
    .s_axi_awaddr(aa), .s_axi_awvalid(av), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ra), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .host_irq(irq)
  );
  // 25 mhz clock
  always #20 mclk = ~mclk;
  // expected status view
  function automatic logic [31:0] xs(input logic [31:0] f);
    return f | {29'h0, f != 32'h0, 2'h0};
  endfunction
  // bus write, response noted
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic pa, pw;
    wq.push_back(r);
    pa = 1;
    pw = 1;
    @(posedge mclk);
    aa <= a; wd <= d; av <= 1; wv <= 1; br <= 1;
    while (pa || pw)
    begin
      @(negedge mclk);
      pa = pa && awr !== 1'b1;
      pw = pw && wrd !== 1'b1;
      @(posedge mclk);
      if (!pa) av <= 0;
      if (!pw) wv <= 0;
    end
    do @(negedge mclk); while (bv !== 1'b1);
    @(posedge mclk) br <= 0;
  endtask : wr
  // bus read, data noted
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    rq.push_back({r, e});
    @(posedge mclk);
    ra <= a; arv <= 1; rr <= 1;
    do @(negedge mclk); while (arr !== 1'b1);
    @(posedge mclk) arv <= 0;
    do @(negedge mclk); while (rv !== 1'b1);
    @(posedge mclk) rr <= 0;
  endtask : rd
  task chk_st(input logic [31:0] f);
    rd(ADDR_STATUS, xs(f), RESP_OKAY);
  endtask : chk_st
  task pulse(input int i);
    @(posedge mclk) ev[i] <= 1;
    @(posedge mclk) ev[i] <= 0;
  endtask : pulse
  task end_sim;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // response monitor against notes
  always @(negedge mclk)
  begin
    if (rv === 1'b1 && rr)
    begin
      re = rq.pop_front();
      `CHK({rresp, rdata}, re)
    end
    if (bv === 1'b1 && br)
    begin
      we = wq.pop_front();
      `CHK(bresp, we)
    end
  end
  // watchdog, far beyond the expected run
  initial
  begin
    #800000;
    err_count++;
    end_sim();
  end
  // main sequence
  initial
  begin
    void'($urandom(11192));
    repeat (16) @(posedge mclk);
    rst <= 0;
    chk_st(0);
    rd(ADDR_ENABLE, 0, RESP_OKAY);
    rd(8'h20, 0, RESP_SLVERR);
    wr(8'h24, 0, RESP_SLVERR);
    for (int i = 0; i < NUM_EVENTS; i++)
    begin
      st = 32'h1 << (i + BIT_FIRST_EVENT);
      pulse(i);
      chk_st(st);
      wr(ADDR_STATUS, ~st & EVENT_MASK, RESP_OKAY);
      chk_st(st);
      wr(ADDR_STATUS, st, RESP_OKAY);
      chk_st(0);
    end
    @(posedge mclk) ev[0] <= 1;
    wr(ADDR_STATUS, 32'h8, RESP_OKAY);
    chk_st(32'h8);
    @(posedge mclk) ev[0] <= 0;
    wr(ADDR_STATUS, EVENT_MASK, RESP_OKAY);
    v = $urandom | 32'h1;
    @(posedge mclk) ext <= v;
    rd(ADDR_STATUS, 32'h2, RESP_OKAY);
    rd(ADDR_EXT_STATUS, v, RESP_OKAY);
    @(posedge mclk) ext <= 0;
    wr(ADDR_TEST_CTRL, 32'h1, RESP_OKAY);
    v = $urandom | 32'h2;
    wr(ADDR_STATUS, v, RESP_OKAY);
    chk_st(v & EVENT_MASK);
    wr(ADDR_STATUS, 0, RESP_OKAY);
    chk_st(0);
    wr(ADDR_TEST_CTRL, 0, RESP_OKAY);
    wr(ADDR_ENABLE, 32'h8, RESP_OKAY);
    rd(ADDR_ENABLE, 32'h8, RESP_OKAY);
    pulse(1);
    repeat (3) @(negedge mclk);
    `CHK(irq, 1'b0)
    pulse(0);
    repeat (3) @(negedge mclk);
    `CHK(irq, 1'b1)
    @(posedge mclk) soft_reset <= 1;
    @(posedge mclk) soft_reset <= 0;
    repeat (3) @(negedge mclk);
    `CHK(irq, 1'b0)
    chk_st(0);
    rd(ADDR_ENABLE, 0, RESP_OKAY);
    end_sim();
  end
endmodule : test_link_group0_event_status
